// >>> hdl/mmie_pkg.sv
// Function
// - The bank-select load (high byte 0000 0001) writes the low four bits of its literal into the bank select register.
// - After a bank-select load the upper four bits of the bank select register are zero.
// - The working load (high byte 0000 1110) puts its literal into the working register and touches no flag.
// - The store-working instruction (0110 111a) copies the working register into the addressed file register.
// - The store-working file field reaches every location of a 256-byte bank.
// - With the bank-access bit clear the store-working instruction addresses the access bank.
// - With the bank-access bit set the bank select register gives the upper address bits.
// - With the access bit clear, extended set on and address at most 95, indexed literal offset mode is used.
// - The literal multiply (high byte 0000 1101) forms the unsigned 16-bit product of working and literal.
// - The product high byte goes to product_high, the low byte to product_low, the working register unchanged.
// - The literal multiply changes no status flag.
// - The file-to-file move is two words, a 12-bit source then a 12-bit destination, each 000h to FFFh.
package mmie_pkg;
  localparam logic [7:0]  OP_LOAD_BANK   = 8'h01;
  localparam logic [7:0]  OP_LOAD_WORK   = 8'h0E;
  localparam logic [7:0]  OP_MULTIPLY    = 8'h0D;
  localparam logic [6:0]  OP_STORE_WORK  = 7'h37;
  localparam logic [3:0]  OP_MOVE_FIRST  = 4'hC;
  localparam logic [3:0]  OP_MOVE_SECOND = 4'hF;
  localparam logic [7:0]  INDEXED_LIMIT  = 8'h5F;
  localparam logic [3:0]  ACCESS_LOW_BANK  = 4'h0;
  localparam logic [3:0]  ACCESS_HIGH_BANK = 4'hF;
  localparam logic [7:0]  RESET_BYTE     = 8'h00;
  localparam logic [11:0] RESET_ADDR     = 12'h000;
  typedef enum logic [3:0] {
    MMIE_Q1 = 4'b0001,
    MMIE_Q2 = 4'b0010,
    MMIE_Q3 = 4'b0100,
    MMIE_Q4 = 4'b1000
  } mmie_phase_t;
endpackage : mmie_pkg

// >>> hdl/mmie_multiplier.sv
module mmie_multiplier #(
  parameter int WIDTH = 8
) (
  // operands
  input  wire logic [WIDTH-1:0]   a,
  input  wire logic [WIDTH-1:0]   b,
  // result
  output logic      [2*WIDTH-1:0] product
);
  import mmie_pkg::*;
  always_comb begin
    product = {{WIDTH{1'b0}}, a} * {{WIDTH{1'b0}}, b};
  end
endmodule : mmie_multiplier

// >>> hdl/mmie_core.sv
module mmie_core (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic        enable,
  // program fetch
  input  wire logic [15:0] opcode,
  input  wire logic        extended_set,
  // data memory
  input  wire logic [7:0]  file_rdata,
  output logic      [11:0] file_addr,
  output logic             file_read,
  output logic             file_write,
  output logic      [7:0]  file_wdata,
  output logic             indexed_mode,
  // state
  output logic      [7:0]  working,
  output logic      [7:0]  bank_select_register,
  output logic      [7:0]  product_high,
  output logic      [7:0]  product_low,
  output logic      [3:0]  phase,
  output logic             move_second,
  output logic             cycle_done
);
  import mmie_pkg::*;

  mmie_phase_t ph, next_ph;
  logic        mv2, next_mv2;
  logic [7:0]  latch_data, next_latch_data;
  logic [7:0]  next_working, next_bank, next_prod_high, next_prod_low;
  logic [11:0] next_addr;
  logic        next_read, next_write, next_indexed, next_done;
  logic [7:0]  next_wdata;
  logic [15:0] product;
  logic        is_bank, is_work, is_mul, is_store, is_move1;

  mmie_multiplier #(.WIDTH(8)) u_mul (
    .a       (working),
    .b       (opcode[7:0]),
    .product (product)
  );

  always_comb begin
    is_bank  = !mv2 && opcode[15:8] == OP_LOAD_BANK;
    is_work  = !mv2 && opcode[15:8] == OP_LOAD_WORK;
    is_mul   = !mv2 && opcode[15:8] == OP_MULTIPLY;
    is_store = !mv2 && opcode[15:9] == OP_STORE_WORK;
    is_move1 = !mv2 && opcode[15:12] == OP_MOVE_FIRST;
    next_ph         = ph;
    next_mv2        = mv2;
    next_latch_data = latch_data;
    next_working    = working;
    next_bank       = bank_select_register;
    next_prod_high  = product_high;
    next_prod_low   = product_low;
    next_addr       = file_addr;
    next_read       = 1'b0;
    next_write      = 1'b0;
    next_wdata      = file_wdata;
    next_indexed    = indexed_mode;
    next_done       = 1'b0;
    case (ph)
      MMIE_Q1: begin
        next_ph = MMIE_Q2;
        if (is_move1) begin
          next_addr = opcode[11:0];
          next_read = 1'b1;
          next_indexed = 1'b0;
        end else if (is_store) begin
          next_indexed = !opcode[8] && extended_set && opcode[7:0] <= INDEXED_LIMIT;
          if (opcode[8]) begin
            next_addr = {bank_select_register[3:0], opcode[7:0]};
          end else if (opcode[7]) begin
            next_addr = {ACCESS_HIGH_BANK, opcode[7:0]};
          end else begin
            next_addr = {ACCESS_LOW_BANK, opcode[7:0]};
          end
        end
      end
      MMIE_Q2: begin
        next_ph = MMIE_Q3;
        if (is_move1) begin
          next_latch_data = file_rdata;
        end
      end
      MMIE_Q3: begin
        next_ph = MMIE_Q4;
        if (mv2) begin
          next_addr  = opcode[11:0];
          next_wdata = latch_data;
          next_write = 1'b1;
        end else if (is_store) begin
          next_wdata = working;
          next_write = 1'b1;
        end
      end
      MMIE_Q4: begin
        next_ph   = MMIE_Q1;
        next_done = 1'b1;
        if (mv2) begin
          next_mv2 = 1'b0;
        end else if (is_move1) begin
          next_mv2 = 1'b1;
        end else if (is_bank) begin
          next_bank = {4'h0, opcode[3:0]};
        end else if (is_work) begin
          next_working = opcode[7:0];
        end else if (is_mul) begin
          next_prod_high = product[15:8];
          next_prod_low  = product[7:0];
        end
      end
      default: begin
        next_ph = MMIE_Q1;
      end
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ph                   <= MMIE_Q1;
      mv2                  <= 1'b0;
      latch_data           <= RESET_BYTE;
      working              <= RESET_BYTE;
      bank_select_register <= RESET_BYTE;
      product_high         <= RESET_BYTE;
      product_low          <= RESET_BYTE;
      file_addr            <= RESET_ADDR;
      file_read            <= 1'b0;
      file_write           <= 1'b0;
      file_wdata           <= RESET_BYTE;
      indexed_mode         <= 1'b0;
      cycle_done           <= 1'b0;
    end else if (enable) begin
      ph                   <= next_ph;
      mv2                  <= next_mv2;
      latch_data           <= next_latch_data;
      working              <= next_working;
      bank_select_register <= next_bank;
      product_high         <= next_prod_high;
      product_low          <= next_prod_low;
      file_addr            <= next_addr;
      file_read            <= next_read;
      file_write           <= next_write;
      file_wdata           <= next_wdata;
      indexed_mode         <= next_indexed;
      cycle_done           <= next_done;
    end
  end

  always_comb begin
    phase       = ph;
    move_second = mv2;
  end

  a_bank_upper_zero: assert property (@(posedge clock) disable iff (!resetn)
    bank_select_register[7:4] == 4'h0) else $error("bank select upper nibble not zero");
  a_bank_load: assert property (@(posedge clock) disable iff (!resetn)
    enable && ph == MMIE_Q4 && is_bank |=> bank_select_register == {4'h0, $past(opcode[3:0])})
    else $error("bank select load wrong");
  a_bank_unchanged: assert property (@(posedge clock) disable iff (!resetn)
    enable && ph == MMIE_Q4 && !is_bank |=> bank_select_register == $past(bank_select_register))
    else $error("bank select changed by other instruction");
  a_work_load: assert property (@(posedge clock) disable iff (!resetn)
    enable && ph == MMIE_Q4 && is_work |=> working == $past(opcode[7:0])) else $error("working load wrong");
  a_work_unchanged: assert property (@(posedge clock) disable iff (!resetn)
    enable && ph == MMIE_Q4 && !is_work |=> working == $past(working))
    else $error("working changed by other instruction");
  a_mul_result: assert property (@(posedge clock) disable iff (!resetn)
    enable && ph == MMIE_Q4 && is_mul |=> {product_high, product_low} == $past(working) * $past(opcode[7:0])
    && working == $past(working)) else $error("product wrong");
  a_store_write: assert property (@(posedge clock) disable iff (!resetn)
    enable && ph == MMIE_Q3 && is_store |=> file_write && file_wdata == $past(working))
    else $error("store write missing");
  a_store_bank: assert property (@(posedge clock) disable iff (!resetn)
    enable && ph == MMIE_Q1 && is_store && opcode[8]
    |=> file_addr == {$past(bank_select_register[3:0]), $past(opcode[7:0])}) else $error("banked address wrong");
  a_store_access: assert property (@(posedge clock) disable iff (!resetn)
    enable && ph == MMIE_Q1 && is_store && !opcode[8]
    |=> file_addr[11:8] == ($past(opcode[7]) ? ACCESS_HIGH_BANK : ACCESS_LOW_BANK)) else $error("access bank wrong");
  a_indexed_sel: assert property (@(posedge clock) disable iff (!resetn)
    enable && ph == MMIE_Q1 && is_store
    |=> indexed_mode == (!$past(opcode[8]) && $past(extended_set) && $past(opcode[7:0]) <= INDEXED_LIMIT))
    else $error("indexed mode wrong");

  // two-word move, source read in cycle one and destination write in cycle two
  a_move_read_addr: assert property (@(posedge clock) disable iff (!resetn)
    enable && ph == MMIE_Q1 && is_move1 |=> file_read && file_addr == $past(opcode[11:0]))
    else $error("move source read wrong");
  a_move_latch: assert property (@(posedge clock) disable iff (!resetn)
    enable && ph == MMIE_Q2 && is_move1 |=> latch_data == $past(file_rdata))
    else $error("move source byte not latched");
  a_move_dest: assert property (@(posedge clock) disable iff (!resetn)
    enable && ph == MMIE_Q3 && mv2
    |=> file_write && file_addr == $past(opcode[11:0]) && file_wdata == $past(latch_data))
    else $error("move destination write wrong");
  a_move_second_set: assert property (@(posedge clock) disable iff (!resetn)
    enable && ph == MMIE_Q4 && is_move1 |=> mv2) else $error("move second cycle not entered");
  a_move_second_clear: assert property (@(posedge clock) disable iff (!resetn)
    enable && ph == MMIE_Q4 && mv2 |=> !mv2) else $error("move second cycle not left");
  a_move_write_q4: assert property (@(posedge clock) disable iff (!resetn)
    file_write |-> ph == MMIE_Q4) else $error("write outside final phase");
  a_move_no_read2: assert property (@(posedge clock) disable iff (!resetn)
    file_read |-> !mv2 && ph == MMIE_Q2) else $error("read outside first cycle read phase");

  // quarter phase walk, done pulse and freeze
  a_phase_q1_q2: assert property (@(posedge clock) disable iff (!resetn)
    enable && ph == MMIE_Q1 |=> ph == MMIE_Q2) else $error("phase did not leave decode");
  a_phase_q2_q3: assert property (@(posedge clock) disable iff (!resetn)
    enable && ph == MMIE_Q2 |=> ph == MMIE_Q3) else $error("phase did not leave read");
  a_phase_q3_q4: assert property (@(posedge clock) disable iff (!resetn)
    enable && ph == MMIE_Q3 |=> ph == MMIE_Q4) else $error("phase did not leave process");
  a_phase_q4_q1: assert property (@(posedge clock) disable iff (!resetn)
    enable && ph == MMIE_Q4 |=> ph == MMIE_Q1) else $error("phase did not leave write");
  a_done_pulse: assert property (@(posedge clock) disable iff (!resetn)
    enable && cycle_done |=> !cycle_done) else $error("done held too long");
  a_freeze_state: assert property (@(posedge clock) disable iff (!resetn)
    !enable |=> ph == $past(ph) && working == $past(working) && file_addr == $past(file_addr)
    && bank_select_register == $past(bank_select_register)) else $error("state moved while frozen");
  a_cycle_four: assert property (@(posedge clock) disable iff (!resetn)
    enable && cycle_done ##1 enable [*3] |=> cycle_done) else $error("cycle not four phases");
endmodule : mmie_core

// >>> test/mmie_data_mem.sv
module mmie_data_mem (
  // core side
  input  wire logic        clock,
  input  wire logic [11:0] file_addr,
  input  wire logic        file_read,
  input  wire logic        file_write,
  input  wire logic [7:0]  file_wdata,
  // read answer
  output logic      [7:0]  file_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [0:4095];
  logic [7:0] last;
  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
    last = 8'h00;
  end
  // idle bus shows the inverse of the last byte read
  assign file_rdata = file_read ? mem[file_addr] : ~last;
  always @(posedge clock) begin
    if (file_read) last <= mem[file_addr];
    if (file_write) mem[file_addr] <= file_wdata;
  end
endmodule : mmie_data_mem

// >>> test/tb_move_multiply_instruction_exec.sv
module tb_move_multiply_instruction_exec;
  timeunit 1ns;
  timeprecision 1ns;
  import mmie_pkg::*;
  typedef struct packed {
    logic [15:0] op;
    logic [7:0]  w, b, ph, pl;
  } mmie_row_t;
  logic        clock, resetn, enable, extended_set, file_read, file_write;
  logic        indexed_mode, move_second, cycle_done;
  logic [15:0] opcode;
  logic [7:0]  file_rdata, file_wdata, working, bank_select_register, product_high, product_low;
  logic [11:0] file_addr;
  logic [3:0]  phase, p;
  int          err_total, num_checks, reads, writes, last_n, r0, w0;
  mmie_row_t   rows [8] = '{
    '{16'h0E5A, 8'h5A, 8'h00, 8'h00, 8'h00}, '{16'h01F5, 8'h5A, 8'h05, 8'h00, 8'h00},
    '{16'h0EE2, 8'hE2, 8'h05, 8'h00, 8'h00}, '{16'h0DC4, 8'hE2, 8'h05, 8'hAD, 8'h08},
    '{16'h0000, 8'hE2, 8'h05, 8'hAD, 8'h08}, '{16'h0EFF, 8'hFF, 8'h05, 8'hAD, 8'h08},
    '{16'h0DFF, 8'hFF, 8'h05, 8'hFE, 8'h01}, '{16'h0D00, 8'hFF, 8'h05, 8'h00, 8'h00}};
  mmie_core u_mmie_core (
    .clock                (clock),
    .resetn               (resetn),
    .enable               (enable),
    .opcode               (opcode),
    .extended_set         (extended_set),
    .file_rdata           (file_rdata),
    .file_addr            (file_addr),
    .file_read            (file_read),
    .file_write           (file_write),
    .file_wdata           (file_wdata),
    .indexed_mode         (indexed_mode),
    .working              (working),
    .bank_select_register (bank_select_register),
    .product_high         (product_high),
    .product_low          (product_low),
    .phase                (phase),
    .move_second          (move_second),
    .cycle_done           (cycle_done)
  );
  mmie_data_mem u_mmie_data_mem (
    .clock      (clock),
    .file_addr  (file_addr),
    .file_read  (file_read),
    .file_write (file_write),
    .file_wdata (file_wdata),
    .file_rdata (file_rdata)
  );
  task automatic chk(input string name, input logic [15:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  // called at a falling edge, returns at the falling edge inside the next decode phase
  task automatic exec(input logic [15:0] op, input logic ext);
    opcode = op;
    extended_set = ext;
    last_n = 0;
    do begin
      @(posedge clock);
      #1;
      last_n++;
    end while (cycle_done !== 1'b1 && last_n < 12);
    if (last_n >= 12) chk("cycle_done", 16'h0, 16'h1);
    @(negedge clock);
  endtask : exec
  task automatic store(input logic [15:0] op, input logic ext, input logic [11:0] a, input logic idx);
    exec(op, ext);
    chk("cycles", 16'(last_n), 16'h4);
    chk("file_addr", file_addr, a);
    chk("stored", u_mmie_data_mem.mem[a], 8'h3C);
    chk("indexed", indexed_mode, idx);
  endtask : store
  task automatic stop_test;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : stop_test
  always @(posedge clock) begin
    if (file_read === 1'b1) reads <= reads + 1;
    if (file_write === 1'b1) writes <= writes + 1;
  end
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  initial begin
    #1000000;
    err_total++;
    stop_test();
  end
  initial begin
    resetn = 1'b0;
    enable = 1'b1;
    extended_set = 1'b0;
    opcode = 16'h0000;
    {err_total, num_checks, reads, writes} = '0;
    repeat (5) @(negedge clock);
    chk("phase", phase, MMIE_Q1);
    chk("product", {product_high, product_low}, 16'h0000);
    chk("regs", {working, bank_select_register}, 16'h0000);
    resetn = 1'b1;
    foreach (rows[i]) begin
      exec(rows[i].op, 1'b0);
      chk("cycles", 16'(last_n), 16'h4);
      chk("working", working, rows[i].w);
      chk("bank", bank_select_register, rows[i].b);
      chk("product", {product_high, product_low}, {rows[i].ph, rows[i].pl});
    end
    exec(16'h0E3C, 1'b0);
    chk("working", working, 8'h3C);
    store(16'h6F20, 1'b0, 12'h520, 1'b0);
    store(16'h6FFF, 1'b0, 12'h5FF, 1'b0);
    store(16'h6E90, 1'b1, 12'hF90, 1'b0);
    store(16'h6E10, 1'b0, 12'h010, 1'b0);
    store(16'h6E5F, 1'b1, 12'h05F, 1'b1);
    store(16'h6E60, 1'b1, 12'h060, 1'b0);
    r0 = reads;
    w0 = writes;
    exec(16'hC520, 1'b0);
    chk("cycles", 16'(last_n), 16'h4);
    // destination kept clear of program counter and stack top
    exec(16'hF7AB, 1'b0);
    chk("cycles", 16'(last_n), 16'h4);
    chk("moved", u_mmie_data_mem.mem[12'h7AB], 8'h3C);
    chk("reads", 16'(reads - r0), 16'h1);
    chk("writes", 16'(writes - w0), 16'h1);
    // freeze in the middle of a cycle
    opcode = 16'h0E33;
    @(negedge clock);
    enable = 1'b0;
    p = phase;
    repeat (3) @(negedge clock);
    chk("frozen", phase, p);
    chk("working", working, 8'h3C);
    enable = 1'b1;
    exec(16'h0E33, 1'b0);
    chk("cycles", 16'(last_n), 16'h3);
    chk("working", working, 8'h33);
    // reset in mid-run
    resetn = 1'b0;
    @(negedge clock);
    chk("phase", phase, MMIE_Q1);
    chk("regs", {working, bank_select_register}, 16'h0000);
    resetn = 1'b1;
    exec(16'h01F5, 1'b0);
    chk("cycles", 16'(last_n), 16'h4);
    chk("bank", bank_select_register, 8'h05);
    stop_test();
  end
endmodule : tb_move_multiply_instruction_exec
